// ---- hdl/ipm_pkg.sv ----
// package for the input polarity and function mux
// assumes a 125 MHz system clock
`default_nettype none
package ipm_pkg;
	localparam int IPM_NUM_IN = 9;
	localparam int IPM_CLK_MHZ = 125;
	localparam int IPM_HOLD_MS = 10;
	localparam int IPM_HOLD_CYC = IPM_HOLD_MS * 1000 * IPM_CLK_MHZ;
	localparam int IPM_CNT_W = 21;
	// register byte addresses
	localparam logic [7:0] IPM_ADDR_POL = 8'h00;
	localparam logic [7:0] IPM_ADDR_CFG = 8'h04;
	localparam logic [7:0] IPM_ADDR_STAT = 8'h08;
	localparam logic [7:0] IPM_ADDR_IRQ = 8'h0c;
	localparam logic [7:0] IPM_ADDR_MASK = 8'h10;
	localparam logic [7:0] IPM_ADDR_LVL = 8'h14;
	// config register fields
	localparam int IPM_CFG_MODE_LSB = 0;
	localparam int IPM_CFG_TLM_BIT = 2;
	localparam int IPM_CFG_IN4_BIT = 3;
	// status fields
	localparam int IPM_ST_TRIP_BIT = 0;
	// irq bits
	localparam int IPM_IRQ_CLR = 0;
	localparam int IPM_IRQ_ACL = 1;
	localparam int IPM_IRQ_W = 2;
	// reset values
	localparam logic [8:0] IPM_POL_RST = 9'h000;
	localparam logic [3:0] IPM_CFG_RST = 4'h0;
	localparam logic [1:0] IPM_MASK_RST = 2'h0;
	typedef enum logic [1:0]
	{
		IPM_MODE_SPEED = 2'h0,
		IPM_MODE_POS = 2'h1,
		IPM_MODE_CSPEED = 2'h2,
		IPM_MODE_CPOS = 2'h3
	} ipm_mode_t;
endpackage
`default_nettype wire

// ---- hdl/ipm_mux.sv ----
// input terminal conditioning, polarity and function routing
// assumes terminals already synchronous to clk_sys
// What this block does
// - current flowing means input asserted
// - nine per-terminal polarity bits, default normal
// - in compat modes shared input is brake, alarm clear when tripped
// - shared output busy, alarm code when tripped
// - config bit swaps busy for torque limit
// - unsupported functions unselectable per mode
// - terminal 4 data-select bit 2 or thermostat
// - select bits form number 0..7, bit 3 held zero
// - alarm reset on falling edge clears alarm
//
// Decided for this implementation: strobed register access and the placing of the registers.
`default_nettype none
module ipm_mux
	import ipm_pkg::*;
(
	// clock and reset
	input  wire logic                  clk_sys,
	input  wire logic                  nrst,
	// register port
	input  wire logic [7:0]            reg_addr,
	input  wire logic [31:0]           reg_wdata,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	output logic      [31:0]           reg_rdata,
	// terminals and device state
	input  wire logic [8:0]            input_terminals,
	input  wire logic                  trip_event,
	input  wire logic                  busy_state,
	input  wire logic                  torque_limit_reached,
	input  wire logic [7:0]            alarm_code,
	// decoded functions
	output logic                       run_positive,
	output logic                       run_negative,
	output logic                       run_clockwise,
	output logic                       run_counterclockwise,
	output logic [3:0]                 data_select_bits,
	output logic                       free_cmd,
	output logic                       stop_cmd,
	output logic                       brake_cmd,
	output logic                       alarm_clear_input,
	output logic                       alarm_reset_input,
	output logic                       regen_thermostat_input,
	output logic                       start_cmd,
	output logic                       home_cmd,
	output logic                       home_sensor,
	output logic                       alarm_active,
	output logic                       shared_out,
	output logic                       alarm_code_output,
	output logic                       irq
);
	import ipm_pkg::*;

	// ***********************
	// registers
	// ***********************
	logic [8:0]           pol_reg;
	logic [3:0]           cfg_reg;
	logic [1:0]           mask_reg;
	logic [1:0]           irq_reg;
	logic [1:0]           irq_next;
	logic                 trip_reg;
	logic                 trip_next;
	logic [8:0]           filt_reg;
	logic                 acl_prev_reg;
	logic                 rst_prev_reg;
	logic [31:0]          rdata_reg;
	logic [7:0]           code_reg;
	logic [7:0]           shift_reg;

	wire ipm_mode_t mode = ipm_mode_t'(cfg_reg[IPM_CFG_MODE_LSB +: 2]);
	wire logic compat = (mode == IPM_MODE_CSPEED) || (mode == IPM_MODE_CPOS);
	wire logic posmode = (mode == IPM_MODE_POS) || (mode == IPM_MODE_CPOS);

	// ***********************
	// polarity and filter
	// ***********************
	// terminal high means current flows
	wire logic [8:0] pol_in = input_terminals ^ pol_reg;

	// filter holds until level stable 10 ms
	// shorter pulses never reach the decode
	genvar gi;
	generate
		for (gi = 0; gi < IPM_NUM_IN; gi++)
		begin : g_filt
			logic [IPM_CNT_W-1:0] cnt_reg;
			always_ff @(posedge clk_sys)
			begin
				if (!nrst)
				begin
					cnt_reg <= '0;
					filt_reg[gi] <= 1'b0;
				end
				else if (pol_in[gi] == filt_reg[gi])
					cnt_reg <= '0;
				else if (cnt_reg == IPM_CNT_W'(IPM_HOLD_CYC - 1))
				begin
					cnt_reg <= '0;
					filt_reg[gi] <= pol_in[gi];
				end
				else
					cnt_reg <= cnt_reg + 1'b1;
			end
		end
	endgenerate

	// ***********************
	// function decode
	// ***********************
	// run, start, home, stop, brake and alarm input functions gated by active mode
	assign run_positive = !compat && filt_reg[0] && !posmode;
	assign run_negative = !compat && filt_reg[1] && !posmode;
	assign run_clockwise = (mode == IPM_MODE_CSPEED) && filt_reg[0];
	assign run_counterclockwise = (mode == IPM_MODE_CSPEED) && filt_reg[1];
	assign home_cmd = (mode == IPM_MODE_POS) && filt_reg[0];
	assign start_cmd = ((mode == IPM_MODE_POS) && filt_reg[1]) || ((mode == IPM_MODE_CPOS) && filt_reg[0]);
	assign home_sensor = ((mode == IPM_MODE_CPOS) && filt_reg[1]) || ((mode == IPM_MODE_POS) && filt_reg[8]);
	wire logic in4_th = cfg_reg[IPM_CFG_IN4_BIT];
	assign regen_thermostat_input = in4_th && filt_reg[4];
	assign data_select_bits = {1'b0, filt_reg[4] & !in4_th, filt_reg[3], filt_reg[2]};
	assign free_cmd = filt_reg[5];
	assign stop_cmd = !compat && filt_reg[6];
	// shared input changes role on trip
	assign brake_cmd = compat && !trip_reg && filt_reg[6];
	assign alarm_clear_input = compat && trip_reg && filt_reg[6];
	assign alarm_reset_input = !compat && filt_reg[7];
	assign alarm_active = trip_reg;

	// falling edge of reset input clears
	wire logic rst_fall = rst_prev_reg && !alarm_reset_input;
	wire logic acl_fall = acl_prev_reg && !alarm_clear_input;
	wire logic clr_ev = trip_reg && (rst_fall || acl_fall);
	// a new trip in the clearing cycle wins
	assign trip_next = trip_event ? 1'b1 : (clr_ev ? 1'b0 : trip_reg);

	// busy normally, alarm code on trip
	// config swaps busy for torque limit
	wire logic busy_sel = cfg_reg[IPM_CFG_TLM_BIT] ? torque_limit_reached : busy_state;
	// gated so a stale code bit never leaks out in the cycle after the clear
	assign alarm_code_output = trip_reg && shift_reg[0];
	assign shared_out = trip_reg ? alarm_code_output : busy_sel;

	// ***********************
	// register port
	// ***********************
	wire logic wr_pol = reg_wr && (reg_addr == IPM_ADDR_POL);
	wire logic wr_cfg = reg_wr && (reg_addr == IPM_ADDR_CFG);
	wire logic wr_irq = reg_wr && (reg_addr == IPM_ADDR_IRQ);
	wire logic wr_mask = reg_wr && (reg_addr == IPM_ADDR_MASK);
	wire logic [1:0] irq_set = {acl_fall && trip_reg, trip_event && !trip_reg};
	// set wins over write-one-to-clear
	assign irq_next = irq_set | (irq_reg & ~(wr_irq ? reg_wdata[1:0] : 2'h0));
	assign irq = |(irq_reg & mask_reg);
	assign reg_rdata = rdata_reg;

	wire logic [31:0] rd_mux =
		(reg_addr == IPM_ADDR_POL)  ? {23'h0, pol_reg} :
		(reg_addr == IPM_ADDR_CFG)  ? {28'h0, cfg_reg} :
		(reg_addr == IPM_ADDR_STAT) ? {23'h0, code_reg, trip_reg} :
		(reg_addr == IPM_ADDR_IRQ)  ? {30'h0, irq_reg} :
		(reg_addr == IPM_ADDR_MASK) ? {30'h0, mask_reg} :
		(reg_addr == IPM_ADDR_LVL)  ? {23'h0, filt_reg} : 32'h0;

	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
		begin
			pol_reg <= IPM_POL_RST;
			cfg_reg <= IPM_CFG_RST;
			mask_reg <= IPM_MASK_RST;
			irq_reg <= 2'h0;
			rdata_reg <= 32'h0;
		end
		else
		begin
			if (wr_pol)
				pol_reg <= reg_wdata[8:0];
			if (wr_cfg)
				cfg_reg <= reg_wdata[3:0];
			if (wr_mask)
				mask_reg <= reg_wdata[1:0];
			irq_reg <= irq_next;
			rdata_reg <= reg_rd ? rd_mux : 32'h0;
		end
	end

	// ***********************
	// alarm state
	// ***********************
	// alarm code shifts out lsb first, repeating
	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
		begin
			trip_reg <= 1'b0;
			rst_prev_reg <= 1'b0;
			acl_prev_reg <= 1'b0;
			code_reg <= 8'h00;
			shift_reg <= 8'h00;
		end
		else
		begin
			trip_reg <= trip_next;
			rst_prev_reg <= alarm_reset_input;
			acl_prev_reg <= alarm_clear_input;
			if (trip_event && !trip_reg)
			begin
				code_reg <= alarm_code;
				shift_reg <= alarm_code;
			end
			else if (trip_reg)
				shift_reg <= {shift_reg[0], shift_reg[7:1]};
			else
				shift_reg <= 8'h00;
		end
	end
endmodule
`default_nettype wire

// ---- bench/ipm_relay_model.sv ----
// relay bank model feeding the opto inputs
// assumes bench changes levels only after the hold time
`default_nettype none
module ipm_relay_model
(
	// bench requests
	input  wire logic [8:0] level_req,
	input  wire logic [8:0] glitch,
	// opto side
	output logic      [8:0] input_terminals
);
	timeunit 1ns;
	timeprecision 1ps;
	assign input_terminals = level_req ^ glitch;
endmodule
`default_nettype wire

// ---- bench/ipm_mux_checker.sv ----
// port assertions for ipm_mux
// assumes one clock domain
`default_nettype none
module ipm_mux_checker
(
	// clock and reset
	input wire logic        clk_sys,
	input wire logic        nrst,
	// watched ports
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic [8:0]  input_terminals,
	input wire logic        trip_event,
	input wire logic        busy_state,
	input wire logic        torque_limit_reached,
	input wire logic [3:0]  data_select_bits,
	input wire logic        free_cmd,
	input wire logic        brake_cmd,
	input wire logic        alarm_active,
	input wire logic        shared_out,
	input wire logic        alarm_code_output
);
	logic        in5_q;
	logic [20:0] hold_cnt;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	// loose bound, catches a missing filter
	always_ff @(posedge clk_sys)
	begin
		in5_q <= input_terminals[5];
		hold_cnt <= (!nrst || input_terminals[5] != in5_q) ? 21'h0 : hold_cnt + {20'h0, ~&hold_cnt};
	end
	sequence s_trip; trip_event; endsequence
	property p_trip_set; s_trip |=> alarm_active; endproperty
	property p_brake_off; alarm_active |-> !brake_cmd; endproperty
	property p_alp_on; alarm_active |-> shared_out == alarm_code_output; endproperty
	property p_alp_off; !alarm_active |-> !alarm_code_output; endproperty
	property p_busy_sel; !alarm_active |-> shared_out == busy_state || shared_out == torque_limit_reached; endproperty
	property p_m3_zero; data_select_bits[3] == 1'b0; endproperty
	property p_rd_idle; !reg_rd |=> reg_rdata == 32'h0; endproperty
	property p_filter; $changed(free_cmd) |-> hold_cnt > 21'h3e8; endproperty
	a_trip_set:
	assert property (p_trip_set) else $error("trip not latched");
	a_brake_off:
	assert property (p_brake_off) else $error("brake while tripped");
	a_alp_on:
	assert property (p_alp_on) else $error("shared out not code");
	a_alp_off:
	assert property (p_alp_off) else $error("code out while idle");
	a_busy_sel:
	assert property (p_busy_sel) else $error("shared out wrong");
	a_m3_zero:
	assert property (p_m3_zero) else $error("select bit 3 set");
	a_rd_idle:
	assert property (p_rd_idle) else $error("read data not idle");
	a_filter:
	assert property (p_filter) else $error("short pulse passed");
endmodule
bind ipm_mux ipm_mux_checker chk (.clk_sys, .nrst, .reg_rd, .reg_rdata, .input_terminals, .trip_event,
	.busy_state, .torque_limit_reached, .data_select_bits, .free_cmd, .brake_cmd, .alarm_active, .shared_out,
	.alarm_code_output);
`default_nettype wire

// ---- bench/test_driver_input_polarity_and_function_mux.sv ----
// self-checking bench for ipm_mux
// assumes relay model and checker compiled first
`default_nettype none
module test_driver_input_polarity_and_function_mux;
	timeunit 1ns;
	timeprecision 1ps;
	import ipm_pkg::*;
	logic        clk_sys = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic        trip_event = 1'b0, busy_state = 1'b0, tlm_in = 1'b0;
	logic [7:0]  reg_addr = 8'h00, alarm_code = 8'h00, b;
	logic [31:0] reg_wdata = 32'h0, reg_rdata;
	logic [8:0]  glitch = 9'h000, input_terminals;
	logic        free_cmd, alarm_active, shared_out, alarm_code_output, irq;
	int          err_total = 0, n_tests = 0;
	// address, write data, read back
	logic [71:0] rows [7] = '{{IPM_ADDR_POL, 32'hffffffff, 32'h1ff}, {IPM_ADDR_CFG, 32'hffffffff, 32'hf},
		{IPM_ADDR_MASK, 32'hffffffff, 32'h3}, {8'h40, 32'hffffffff, 32'h0}, {IPM_ADDR_LVL, 32'hffffffff, 32'h0},
		{IPM_ADDR_POL, 32'h0, 32'h0}, {IPM_ADDR_CFG, 32'h0, 32'h0}};
	ipm_relay_model relay (.level_req(9'h000), .glitch, .input_terminals);
	ipm_mux uut (.clk_sys, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .input_terminals,
		.trip_event, .busy_state, .torque_limit_reached(tlm_in), .alarm_code, .run_positive(), .run_negative(),
		.run_clockwise(), .run_counterclockwise(), .data_select_bits(), .free_cmd, .stop_cmd(), .brake_cmd(),
		.alarm_clear_input(), .alarm_reset_input(), .regen_thermostat_input(), .start_cmd(), .home_cmd(),
		.home_sensor(), .alarm_active, .shared_out, .alarm_code_output, .irq);
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			err_total++;
			$display("Error at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, e);
	endtask
	task automatic close_out;
		$display("errors %0d compares %0d", err_total, n_tests);
		if (err_total == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial
	begin
		forever #4 clk_sys = ~clk_sys;
	end
	// run takes under a thousand cycles
	initial
	begin
		repeat (50000) @(posedge clk_sys);
		err_total++;
		close_out;
	end
	initial
	begin
		repeat (20) @(posedge clk_sys);
		nrst <= 1'b1;
		rd(IPM_ADDR_POL, 32'h0);
		rd(IPM_ADDR_MASK, 32'h0);
		foreach (rows[i])
		begin
			wr(rows[i][71:64], rows[i][63:32]);
			rd(rows[i][71:64], rows[i][31:0]);
		end
		glitch <= 9'h020;
		repeat (600) @(posedge clk_sys);
		glitch <= 9'h000;
		rd(IPM_ADDR_LVL, 32'h0);
		chk({31'h0, free_cmd}, 32'h0);
		@(posedge clk_sys) busy_state <= 1'b1;
		#1 chk({31'h0, shared_out}, 32'h1);
		wr(IPM_ADDR_CFG, 32'h4);
		#1 chk({31'h0, shared_out}, 32'h0);
		wr(IPM_ADDR_CFG, 32'h0);
		wr(IPM_ADDR_MASK, 32'h1);
		@(posedge clk_sys);
		alarm_code <= 8'ha5;
		trip_event <= 1'b1;
		@(posedge clk_sys);
		trip_event <= 1'b0;
		#1 chk({30'h0, alarm_active, irq}, 32'h3);
		rd(IPM_ADDR_STAT, 32'h14b);
		repeat (8)
		begin
			@(posedge clk_sys);
			#1 b = {alarm_code_output, b[7:1]};
		end
		chk({28'h0, 4'($countones(b))}, 32'h4);
		wr(IPM_ADDR_MASK, 32'h0);
		#1 chk({31'h0, irq}, 32'h0);
		wr(IPM_ADDR_IRQ, 32'h1);
		rd(IPM_ADDR_IRQ, 32'h0);
		@(posedge clk_sys) nrst <= 1'b0;
		repeat (2) @(posedge clk_sys);
		nrst <= 1'b1;
		rd(IPM_ADDR_STAT, 32'h0);
		close_out;
	end
endmodule
`default_nettype wire
